// *** core/pmc_defines.svh ***
// Constants of the performance event counter block
// Functional notes
// - Cycle counter counts every cycle or per 64
// - Several 32-bit event counters, each selects event
// - Enable, reset controls and overflow status flags
// - Overflow interrupt gated by per-counter enables
// - Cycle counter enable independent of event counters
// - Privileged access always; user blocked unless granted
// - User grant excludes interrupt enable set/clear
// - Counting never alters core execution
// - Core software and debug both reach counters
// - Code 0x00 counts software increment writes
// - Codes 0x01/0x03/0x04 count L1 cache events
// - Codes 0x06/0x07/0x08 count executed instructions
// - Codes 0x09/0x0A count exception entry/return
// - Codes 0x0B/0x0C count context ID, PC writes
// - Codes 0x0D/0x0E/0x0F count branches, returns, unaligned
// - Codes 0x10/0x12 count mispredicts, predictable branches
// - Code 0x11 counts every core cycle
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_NUM_CNT 4
`define PMC_CYC_BIT 4
`define PMC_DIV 6'h3f
`define PMC_SEL_CTRL 4'h0
`define PMC_SEL_EN_SET 4'h1
`define PMC_SEL_EN_CLR 4'h2
`define PMC_SEL_OVF 4'h3
`define PMC_SEL_SWINC 4'h4
`define PMC_SEL_CCNT 4'h5
`define PMC_SEL_EVCNT 4'h6
`define PMC_SEL_EVSEL 4'h7
`define PMC_SEL_USER 4'h8
`define PMC_SEL_IEN_SET 4'h9
`define PMC_SEL_IEN_CLR 4'ha
`define PMC_CTRL_EN 0
`define PMC_CTRL_RST_EVT 1
`define PMC_CTRL_RST_CYC 2
`define PMC_CTRL_DIV64 3
`define PMC_EV_SWINC 8'h00
`define PMC_EV_CYCLE 8'h11
`define PMC_EV_LAST 8'h12
`define PMC_CNT_RESET 32'h0000_0000
`endif

// *** core/pmc_pkg.sv ***
// Types of the performance event counter block
package pmc_pkg;
    typedef enum logic [3:0] {
        SEL_CTRL = 4'h0,
        SEL_EN_SET = 4'h1,
        SEL_EN_CLR = 4'h2,
        SEL_OVF = 4'h3,
        SEL_SWINC = 4'h4,
        SEL_CCNT = 4'h5,
        SEL_EVCNT = 4'h6,
        SEL_EVSEL = 4'h7,
        SEL_USER = 4'h8,
        SEL_IEN_SET = 4'h9,
        SEL_IEN_CLR = 4'ha
    } pmc_sel_t;

    typedef struct packed {
        logic [31:0] ccnt;
        logic [5:0] pre;
        logic [3:0][31:0] evcnt;
        logic [3:0][7:0] evsel;
        logic [4:0] cnten;
        logic [4:0] ovf;
        logic [4:0] inten;
        logic glob_en;
        logic div64;
        logic user_en;
        logic [31:0] rdata;
        logic ack;
        logic err;
    } pmc_state_t;
endpackage

// *** core/pmc_top.sv ***
// Performance event counters with register access port
`timescale 1ns/10ps
`include "pmc_defines.svh"
module pmc_top
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Event pulses from the core, bit n is event code n
    input wire logic [18:0] evt_i,
    // Register access from core software or debug
    input wire logic acc_req_i,
    input wire logic acc_wr_i,
    input wire logic acc_priv_i,
    input wire logic acc_dbg_i,
    input wire logic [3:0] acc_sel_i,
    input wire logic [1:0] acc_idx_i,
    input wire logic [31:0] acc_wdata_i,
    output logic acc_ack_o,
    output logic acc_err_o,
    output logic [31:0] acc_rdata_o,
    // Overflow interrupt
    output logic ovf_irq_o
);
    pmc_pkg::pmc_state_t st;
    pmc_pkg::pmc_state_t next_st;
    logic acc_ok;
    logic wr_ok;
    logic cyc_tick;
    logic [4:0] ovf_clr;
    logic [3:0] sw_inc;
    logic [32:0] sum;
    logic [4:0] wrap;

    function automatic logic [32:0] step32(input logic [31:0] v, input logic inc);
        step32 = {1'b0, v} + {32'h0000_0000, inc};
    endfunction

    function automatic logic evt_hit(input logic [7:0] code, input logic [18:0] ev, input logic sw);
        logic hit;
        hit = 1'b0;
        case (code)
            `PMC_EV_SWINC: hit = sw;
            8'h01, 8'h03, 8'h04: hit = ev[code[4:0]];
            8'h06, 8'h07, 8'h08: hit = ev[code[4:0]];
            8'h09, 8'h0a: hit = ev[code[4:0]];
            8'h0b, 8'h0c: hit = ev[code[4:0]];
            8'h0d, 8'h0e, 8'h0f: hit = ev[code[4:0]];
            8'h10, `PMC_EV_LAST: hit = ev[code[4:0]];
            `PMC_EV_CYCLE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        evt_hit = hit;
    endfunction

    // Debug and privileged always pass; user needs the grant
    always_comb
    begin
        acc_ok = acc_priv_i | acc_dbg_i;
        if (!acc_ok && st.user_en && acc_sel_i != `PMC_SEL_IEN_SET && acc_sel_i != `PMC_SEL_IEN_CLR)
        begin
            acc_ok = 1'b1;
        end
        wr_ok = acc_req_i & acc_wr_i & acc_ok;
    end

    assign ovf_clr = (wr_ok && acc_sel_i == `PMC_SEL_OVF) ? acc_wdata_i[4:0] : 5'h00;
    assign sw_inc = (wr_ok && acc_sel_i == `PMC_SEL_SWINC) ? acc_wdata_i[3:0] : 4'h0;
    assign cyc_tick = st.glob_en & st.cnten[`PMC_CYC_BIT] & (!st.div64 || st.pre == `PMC_DIV);

    always_comb
    begin
        next_st = st;
        sum = 33'h0_0000_0000;
        wrap = 5'h00;
        next_st.ack = acc_req_i;
        next_st.err = acc_req_i & ~acc_ok;
        next_st.rdata = 32'h0000_0000;
        // Counting
        if (st.glob_en && st.cnten[`PMC_CYC_BIT])
        begin
            next_st.pre = st.pre + 6'h01;
        end
        sum = step32(st.ccnt, cyc_tick);
        next_st.ccnt = sum[31:0];
        wrap[`PMC_CYC_BIT] = sum[32];
        for (int i = 0; i < `PMC_NUM_CNT; i++)
        begin
            sum = step32(st.evcnt[i], st.glob_en & st.cnten[i] & evt_hit(st.evsel[i], evt_i, sw_inc[i]));
            next_st.evcnt[i] = sum[31:0];
            wrap[i] = sum[32];
        end
        // Reads
        if (acc_req_i && acc_ok && !acc_wr_i)
        begin
            case (acc_sel_i)
                `PMC_SEL_CTRL: next_st.rdata = {28'h000_0000, st.div64, 2'b00, st.glob_en};
                `PMC_SEL_EN_SET, `PMC_SEL_EN_CLR: next_st.rdata = {27'h000_0000, st.cnten};
                `PMC_SEL_OVF: next_st.rdata = {27'h000_0000, st.ovf};
                `PMC_SEL_CCNT: next_st.rdata = st.ccnt;
                `PMC_SEL_EVCNT: next_st.rdata = st.evcnt[acc_idx_i];
                `PMC_SEL_EVSEL: next_st.rdata = {24'h00_0000, st.evsel[acc_idx_i]};
                `PMC_SEL_USER: next_st.rdata = {31'h0000_0000, st.user_en};
                `PMC_SEL_IEN_SET, `PMC_SEL_IEN_CLR: next_st.rdata = {27'h000_0000, st.inten};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Writes override counting in the same cycle
        if (wr_ok)
        begin
            case (acc_sel_i)
                `PMC_SEL_CTRL:
                begin
                    next_st.glob_en = acc_wdata_i[`PMC_CTRL_EN];
                    next_st.div64 = acc_wdata_i[`PMC_CTRL_DIV64];
                    if (acc_wdata_i[`PMC_CTRL_RST_EVT])
                    begin
                        next_st.evcnt = {`PMC_NUM_CNT{`PMC_CNT_RESET}};
                        wrap[3:0] = 4'h0;
                    end
                    if (acc_wdata_i[`PMC_CTRL_RST_CYC])
                    begin
                        next_st.ccnt = `PMC_CNT_RESET;
                        wrap[`PMC_CYC_BIT] = 1'b0;
                        next_st.pre = 6'h00;
                    end
                end
                `PMC_SEL_EN_SET: next_st.cnten = st.cnten | acc_wdata_i[4:0];
                `PMC_SEL_EN_CLR: next_st.cnten = st.cnten & ~acc_wdata_i[4:0];
                `PMC_SEL_CCNT: next_st.ccnt = acc_wdata_i;
                `PMC_SEL_EVCNT: next_st.evcnt[acc_idx_i] = acc_wdata_i;
                `PMC_SEL_EVSEL: next_st.evsel[acc_idx_i] = acc_wdata_i[7:0];
                `PMC_SEL_USER: next_st.user_en = acc_wdata_i[0];
                `PMC_SEL_IEN_SET: next_st.inten = st.inten | acc_wdata_i[4:0];
                `PMC_SEL_IEN_CLR: next_st.inten = st.inten & ~acc_wdata_i[4:0];
                default: next_st.ack = acc_req_i;
            endcase
        end
        // Overflow set beats a same-cycle clear; counter resets flag nothing
        next_st.ovf = (st.ovf & ~ovf_clr) | wrap;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs only; no path back into the core pipeline
    assign acc_ack_o = st.ack;
    assign acc_err_o = st.err;
    assign acc_rdata_o = st.rdata;
    assign ovf_irq_o = |(st.ovf & st.inten);

    // Checks
    logic past_wr;
    always_ff @(posedge core_clk_i)
    begin
        past_wr <= rst_i ? 1'b0 : wr_ok;
    end

    ccnt_full_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.glob_en && st.cnten[4] && !st.div64 && !wr_ok) |=> st.ccnt == $past(st.ccnt) + 32'h1)
        else $error("cycle counter missed a cycle");

    ccnt_div_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.div64 && st.pre != 6'h3f && !wr_ok) |=> $stable(st.ccnt))
        else $error("divided cycle counter stepped early");

    ccnt_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!st.cnten[4] && !wr_ok) [*2] |=> $stable(st.ccnt))
        else $error("disabled cycle counter moved");

    cyc_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[1] == 8'h11 && st.glob_en && st.cnten[1] && !wr_ok) |=> st.evcnt[1] == $past(st.evcnt[1]) + 32'h1)
        else $error("cycle event not counted");

    cache_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[0] == 8'h01 && st.glob_en && st.cnten[0] && !wr_ok) |=>
        st.evcnt[0] == $past(st.evcnt[0]) + {31'h0, $past(evt_i[1])})
        else $error("cache refill event miscounted");

    exc_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[2] == 8'h09 && st.glob_en && st.cnten[2] && !wr_ok) |=>
        st.evcnt[2] == $past(st.evcnt[2]) + {31'h0, $past(evt_i[9])})
        else $error("exception event miscounted");

    branch_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[1] == 8'h10 && st.glob_en && st.cnten[1] && !wr_ok) |=>
        st.evcnt[1] == $past(st.evcnt[1]) + {31'h0, $past(evt_i[16])})
        else $error("mispredict event miscounted");

    swinc_count_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_ok && acc_sel_i == 4'h4 && acc_wdata_i[2] && st.evsel[2] == 8'h00 && st.glob_en && st.cnten[2]) |=>
        st.evcnt[2] == $past(st.evcnt[2]) + 32'h1)
        else $error("software increment not counted");

    evt_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!st.glob_en && !wr_ok) |=> $stable(st.evcnt))
        else $error("event counter moved while disabled");

    ack_once_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        acc_req_i |=> acc_ack_o)
        else $error("access not acknowledged");

    ack_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !acc_req_i |=> (!acc_ack_o && !acc_err_o && acc_rdata_o == 32'h0))
        else $error("answer without request");

    err_data_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        acc_err_o |-> acc_rdata_o == 32'h0)
        else $error("refused access returned data");

    inst_event_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[1] == 8'h08 && st.glob_en && st.cnten[1] && !wr_ok) |=>
        st.evcnt[1] == $past(st.evcnt[1]) + {31'h0, $past(evt_i[8])})
        else $error("instruction event miscounted");

    swinc_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.evsel[0] == 8'h00 && st.glob_en && st.cnten[0] && !wr_ok) |=> $stable(st.evcnt[0]))
        else $error("software increment counted without a write");

    wrap_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (cyc_tick && st.ccnt == 32'hffff_ffff && !wr_ok) |=> (st.ccnt == 32'h0 && st.ovf[4]) ##1 st.ovf[4] || past_wr)
        else $error("wrap did not set sticky overflow");

    ovf_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.ovf[0] && !(wr_ok && acc_sel_i == 4'h3)) |=> st.ovf[0])
        else $error("overflow flag dropped without clear");

    user_ien_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (acc_req_i && !acc_priv_i && !acc_dbg_i && acc_sel_i == 4'h9) |=> acc_err_o && $stable(st.inten))
        else $error("user reached interrupt enable set");

    user_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (acc_req_i && !acc_priv_i && !acc_dbg_i && !st.user_en) |=> acc_err_o && acc_ack_o)
        else $error("user access not refused");

    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st.inten == 5'h00) |-> !ovf_irq_o)
        else $error("interrupt without enable");

    wrap_c: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(st.ovf[4]));
    irq_c: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(ovf_irq_o));
    deny_c: cover property (@(posedge core_clk_i) disable iff (rst_i) acc_err_o);
    div_c: cover property (@(posedge core_clk_i) disable iff (rst_i) st.div64 && cyc_tick);
endmodule

// *** verification/pmc_evsrc.sv ***
// Event source model standing in for the core pipeline
`timescale 1ns/10ps
module pmc_evsrc
(
    // Clock
    input wire logic core_clk_i,
    // Burst command from the bench
    input wire logic start_i,
    input wire logic [4:0] code_i,
    // Event pulses to the counters
    output logic [18:0] evt_o
);
    logic [3:0] left = 4'h0;
    logic [4:0] code = 5'h00;
    always @(posedge core_clk_i)
    begin
        if (start_i)
        begin
            left <= 4'h3;
            code <= code_i;
        end
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    // Three pulses on the coded line, unused line 2 rides along
    assign evt_o = (left != 4'h0) ? ((19'h1 << code) | 19'h4) : 19'h0;
endmodule

// *** verification/performance_event_counters_tb.sv ***
// Self-checking bench of the performance event counters
`timescale 1ns/10ps
module performance_event_counters_tb;
    logic core_clk_i, rst_i, acc_req_i, acc_wr_i, acc_priv_i, acc_dbg_i, start, er;
    logic acc_ack_o, acc_err_o, ovf_irq_o;
    logic [18:0] evt_i;
    logic [3:0] acc_sel_i;
    logic [1:0] acc_idx_i;
    logic [4:0] code;
    logic [31:0] acc_wdata_i, acc_rdata_o, rd, v0;
    int mismatches, comparisons, k;
    logic [4:0] codes [0:14] = '{5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
        5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h12};

    pmc_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .evt_i(evt_i), .acc_req_i(acc_req_i),
        .acc_wr_i(acc_wr_i), .acc_priv_i(acc_priv_i), .acc_dbg_i(acc_dbg_i), .acc_sel_i(acc_sel_i),
        .acc_idx_i(acc_idx_i), .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o),
        .acc_err_o(acc_err_o), .acc_rdata_o(acc_rdata_o), .ovf_irq_o(ovf_irq_o));
    pmc_evsrc u_src (.core_clk_i(core_clk_i), .start_i(start), .code_i(code), .evt_o(evt_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task idle(input int n);
        acc_req_i = 1'b0;
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // One access; request stays up until the next access or idle
    task acc(input logic w, input logic p, input logic d, input logic [3:0] s, input logic [1:0] i,
        input logic [31:0] wd);
        acc_req_i = 1'b1;
        acc_wr_i = w;
        acc_priv_i = p;
        acc_dbg_i = d;
        acc_sel_i = s;
        acc_idx_i = i;
        acc_wdata_i = wd;
        @(posedge core_clk_i);
        #1;
        rd = acc_rdata_o;
        er = acc_err_o;
        chk(acc_ack_o, 32'h1);
    endtask

    task wr(input logic [3:0] s, input logic [1:0] i, input logic [31:0] wd);
        acc(1'b1, 1'b1, 1'b0, s, i, wd);
    endtask

    task rdp(input logic [3:0] s, input logic [1:0] i);
        acc(1'b0, 1'b1, 1'b0, s, i, 32'h0);
    endtask

    task burst(input logic [4:0] c);
        code = c;
        start = 1'b1;
        idle(1);
        start = 1'b0;
        idle(5);
    endtask

    initial
    begin
        rst_i = 1'b1;
        acc_wr_i = 1'b0;
        acc_priv_i = 1'b0;
        acc_dbg_i = 1'b0;
        acc_sel_i = 4'h0;
        acc_idx_i = 2'h0;
        acc_wdata_i = 32'h0;
        start = 1'b0;
        code = 5'h00;
        mismatches = 0;
        comparisons = 0;
        idle(20);
        rst_i = 1'b0;
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        chk(rd, 32'h0);
        rdp(pmc_pkg::SEL_OVF, 2'h0);
        chk(rd, 32'h0);
        wr(pmc_pkg::SEL_EN_SET, 2'h0, 32'h1f);
        wr(pmc_pkg::SEL_CTRL, 2'h0, 32'h5);
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        v0 = rd;
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        chk(rd, v0 + 32'h1);
        wr(pmc_pkg::SEL_EN_CLR, 2'h0, 32'h10);
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        v0 = rd;
        idle(5);
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        chk(rd, v0);
        // Divided mode: one step in the first 100 cycles
        wr(pmc_pkg::SEL_EN_SET, 2'h0, 32'h10);
        wr(pmc_pkg::SEL_CTRL, 2'h0, 32'hd);
        idle(100);
        rdp(pmc_pkg::SEL_CCNT, 2'h0);
        chk(rd, 32'h1);
        rdp(pmc_pkg::SEL_CTRL, 2'h0);
        chk(rd, 32'h9);
        for (k = 0; k < 15; k++)
        begin
            wr(pmc_pkg::SEL_EVSEL, k[1:0], {27'h0, codes[k]});
            wr(pmc_pkg::SEL_CTRL, 2'h0, 32'h3);
            burst(codes[k]);
            rdp(pmc_pkg::SEL_EVCNT, k[1:0]);
            chk(rd, 32'h3);
        end
        wr(pmc_pkg::SEL_EVSEL, 2'h1, 32'h11);
        rdp(pmc_pkg::SEL_EVCNT, 2'h1);
        v0 = rd;
        rdp(pmc_pkg::SEL_EVCNT, 2'h1);
        chk(rd, v0 + 32'h1);
        // Counter 0 holds code 0x0f, so only counter 2 takes the increment
        wr(pmc_pkg::SEL_EVSEL, 2'h2, 32'h0);
        wr(pmc_pkg::SEL_CTRL, 2'h0, 32'h3);
        wr(pmc_pkg::SEL_SWINC, 2'h0, 32'h5);
        rdp(pmc_pkg::SEL_EVCNT, 2'h2);
        chk(rd, 32'h1);
        rdp(pmc_pkg::SEL_EVCNT, 2'h0);
        chk(rd, 32'h0);
        wr(pmc_pkg::SEL_EN_CLR, 2'h0, 32'h1);
        burst(5'h0f);
        rdp(pmc_pkg::SEL_EVCNT, 2'h0);
        chk(rd, 32'h0);
        wr(pmc_pkg::SEL_EVCNT, 2'h1, 32'hffff_fffe);
        idle(3);
        rdp(pmc_pkg::SEL_OVF, 2'h0);
        chk(rd, 32'h2);
        chk(ovf_irq_o, 32'h0);
        wr(pmc_pkg::SEL_IEN_SET, 2'h0, 32'h2);
        idle(1);
        chk(ovf_irq_o, 32'h1);
        wr(pmc_pkg::SEL_OVF, 2'h0, 32'h2);
        idle(1);
        chk(ovf_irq_o, 32'h0);
        wr(pmc_pkg::SEL_CCNT, 2'h0, 32'hffff_fffe);
        idle(3);
        rdp(pmc_pkg::SEL_OVF, 2'h0);
        chk(rd, 32'h10);
        // Unprivileged, granted, excluded and debug accesses
        acc(1'b0, 1'b0, 1'b0, pmc_pkg::SEL_CCNT, 2'h0, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        wr(pmc_pkg::SEL_USER, 2'h0, 32'h1);
        acc(1'b0, 1'b0, 1'b0, pmc_pkg::SEL_CCNT, 2'h0, 32'h0);
        chk(er, 32'h0);
        acc(1'b1, 1'b0, 1'b0, pmc_pkg::SEL_IEN_SET, 2'h0, 32'h1);
        chk(er, 32'h1);
        acc(1'b1, 1'b0, 1'b1, pmc_pkg::SEL_IEN_CLR, 2'h0, 32'h2);
        chk(er, 32'h0);
        rdp(4'hf, 2'h0);
        chk(rd, 32'h0);
        final_report;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        final_report;
    end
endmodule
